//--- bench/slave_port_forwarding_and_mode_map_bench.sv
// Self-checking bench for the forwarding ring, strap mapping and PHY setup.
// Assumes the management model beside it and zero-wait bus answers.
`timescale 1ns/10ps
`default_nettype none
module slave_port_forwarding_and_mode_map_bench
  import spfmm_pkg::*;
;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic [1:0]    strap = 2'h0;
  logic [2:0]    link = 3'h7;
  spfmm_beat_t   rx [3] = '{default: '0};
  wire spfmm_beat_t tx [3];
  logic          hsel = 1'b0;
  logic [31:0]   haddr = 32'h0;
  logic [1:0]    htrans = 2'h0;
  logic          hwrite = 1'b0;
  logic [31:0]   hwdata = 32'h0;
  wire logic     hready;
  wire logic     hresp;
  wire logic [31:0] hrdata;
  wire logic     m_req;
  wire logic     m_wr;
  wire logic     m_ack;
  wire logic [1:0] m_sel;
  wire spfmm_phycfg_t m_wd;
  wire spfmm_phycfg_t m_rd;
  int            n_fail = 0;
  int            cmp_count = 0;

  always #5 clk = ~clk;

  spfmm_top DUT (.CORE_CLK(clk), .RESET(rst), .PORT_CONFIG_STRAP_HI(strap[1]),
    .PORT_CONFIG_STRAP_LO(strap[0]), .PHY_LINK(link), .PHY_A_RX(rx[0]), .PHY_B_RX(rx[1]),
    .MII_RX(rx[2]), .PHY_A_TX(tx[0]), .PHY_B_TX(tx[1]), .MII_TX(tx[2]), .MGMT_REQ(m_req),
    .MGMT_WR(m_wr), .MGMT_SEL(m_sel), .MGMT_WDATA(m_wd), .MGMT_RDATA(m_rd), .MGMT_ACK(m_ack),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata));

  spfmm_mgmt_model #(.DLY(3)) MODEL (.CORE_CLK(clk), .RESET(rst), .REQ(m_req), .WR(m_wr),
    .SEL(m_sel), .WDATA(m_wd), .RDATA(m_rd), .ACK(m_ack));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'(HRESP_OKAY), 32'(hresp));
  endtask

  task automatic wait_idle();
    logic [31:0] r;
    r = 32'h1000;
    for (int k = 0; k < 80 && r[12] !== 1'b0; k++)
    begin
      ahb(1'b0, 32'(OFS_PORT_STAT), 32'h0, r);
    end
    chk("cfg_busy", 32'h0, 32'(r[12]));
  endtask

  task automatic reset_dut(input logic [1:0] m);
    @(posedge clk);
    strap <= m;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    wait_idle();
  endtask

  // Sends one whole frame of one beat and looks at the port lat cycles on.
  task automatic fwd(input int s, input int d, input string nm, input int lat = 2);
    spfmm_beat_t b;
    b = '{vld: 1'b1, sof: 1'b1, eof: 1'b1, err: 1'b0, data: 8'hA5};
    @(posedge clk);
    rx[s] <= b;
    @(posedge clk);
    rx[s] <= BEAT_IDLE;
    if (lat > 1)
    begin
      @(posedge clk);
    end
    #1;
    chk(nm, 32'(b), 32'(tx[d]));
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_modes();
    logic [31:0] r;
    logic [1:0]  m;
    for (int i = 0; i < 4; i++)
    begin
      m = 2'(i);
      reset_dut(m);
      ahb(1'b0, 32'(OFS_PORT_STAT), 32'h0, r);
      chk("mode", (m == 2'h1) ? 32'h0 : 32'(m), 32'(r[10:9]));
      chk("strap_rsv", 32'(m == 2'h1), 32'(r[11]));
      chk("present", m[1] ? 32'h7 : 32'h3, 32'(r[8:6]));
      chk("phy_a_cfg", 32'h7, 32'(MODEL.cfg[0]));
      strap <= ~m;
      repeat (8) @(posedge clk);
      ahb(1'b0, 32'(OFS_PORT_STAT), 32'h0, r);
      chk("mode_held", (m == 2'h1) ? 32'h0 : 32'(m), 32'(r[10:9]));
      fwd((m == 2'h3) ? 2 : 0, 1, "ring_l0_l1");
    end
    $display("test modes done");
  endtask

  task automatic t_loop();
    logic [31:0] r;
    reset_dut(2'h2);
    ahb(1'b1, 32'(OFS_LOOP_CTRL), 32'h2, r);
    fwd(0, 2, "skip_l1");
    ahb(1'b1, 32'(OFS_LOOP_CTRL), 32'h1, r);
    fwd(2, 1, "l0_to_unit");
    ahb(1'b1, 32'(OFS_LOOP_CTRL), 32'h0, r);
    link <= 3'h5;
    repeat (8) @(posedge clk);
    fwd(0, 2, "no_link_l1");
    fwd(2, 0, "l2_to_l0", 1);
    @(posedge clk);
    link <= 3'h7;
    ahb(1'b1, 32'(OFS_PHY_CTRL), 32'h101, r);
    wait_idle();
    chk("fiber_cfg", 32'h6, 32'(MODEL.cfg[0]));
    ahb(1'b0, 32'h40, 32'h0, r);
    chk("unmapped", 32'h0, r);
    $display("test loop done");
  endtask

  task automatic t_stamp();
    logic [31:0] t0;
    logic [31:0] t1;
    @(posedge clk);
    rx[0] <= '{vld: 1'b1, sof: 1'b1, eof: 1'b1, err: 1'b1, data: 8'h3C};
    @(posedge clk);
    rx[0] <= BEAT_IDLE;
    repeat (19) @(posedge clk);
    rx[1] <= '{vld: 1'b1, sof: 1'b1, eof: 1'b1, err: 1'b0, data: 8'hC3};
    @(posedge clk);
    rx[1] <= BEAT_IDLE;
    ahb(1'b0, 32'(OFS_TS_P0), 32'h0, t0);
    ahb(1'b0, 32'(OFS_TS_P1), 32'h0, t1);
    chk("ts_gap", 32'h14, t1 - t0);
    ahb(1'b0, 32'(OFS_FRM_ERR), 32'h0, t0);
    chk("frm_err", 32'h1, t0 & 32'hFFFF);
    $display("test stamp done");
  endtask

  // ****************************************************************
  // Run control
  // ****************************************************************
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial
  begin
    t_modes();
    t_loop();
    t_stamp();
    print_verdict();
  end

  initial
  begin
    #300000;
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire

//--- bench/spfmm_mgmt_model.sv
// PHY management agent standing for PHY A, PHY B and the external PHY.
// Assumes the engine holds its request until the acknowledge edge.
`timescale 1ns/10ps
`default_nettype none
module spfmm_mgmt_model
  import spfmm_pkg::*;
#(
  parameter int unsigned DLY = 3
)
(
  // Clock and reset
  input  wire logic          CORE_CLK,
  input  wire logic          RESET,
  // Management request
  input  wire logic          REQ,
  input  wire logic          WR,
  input  wire logic [1:0]    SEL,
  input  wire spfmm_phycfg_t WDATA,
  // Management answer
  output spfmm_phycfg_t      RDATA,
  output logic               ACK
);
  // ****************************************************************
  // Configuration store
  // ****************************************************************
  spfmm_phycfg_t cfg [3];
  logic [3:0]    cnt;

  always @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      // PHY A starts wrong on purpose so that a rewrite must follow.
      cfg[0] <= 3'h0;
      cfg[1] <= 3'h7;
      cfg[2] <= 3'h7;
      cnt <= 4'h0;
      ACK <= 1'b0;
      RDATA <= 3'h0;
    end
    else if (REQ && !ACK && cnt == 4'(DLY))
    begin
      ACK <= 1'b1;
      cnt <= 4'h0;
      RDATA <= cfg[SEL];
      if (WR)
      begin
        cfg[SEL] <= WDATA;
      end
    end
    else
    begin
      // Read data is only valid with the acknowledge; it toggles otherwise.
      ACK <= 1'b0;
      RDATA <= ~RDATA;
      cnt <= (REQ && !ACK) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

//--- design/spfmm_pkg.sv
// Constants, carriers and mapping functions of the slave port forwarding block.
// Assumes one 100 MHz core clock and PHY streams already in that clock domain.
//
// Summary of operation
// - Forward order: port0, processing unit, port1, port2.
// - Each port checks frames, then forwards onward.
// - Time stamp every frame on reception.
// - Loop-back on no link, unavailable or closed.
// - Looped port 0 feeds the processing unit.
// - Master opens or closes each port loop.
// - Two-bit strap selects port configuration.
// - Two-port: ports 0,1 on PHYs A,B.
// - Downstream: ports 0,1 internal, port 2 MII.
// - Upstream: port2 PHY A, port1 B, port0 MII.
// - Internal PHYs default to 100 Mbps full-duplex.
// - Autonegotiation on for copper, off for fiber.
// - Core reads back internal PHYs, rewrites mismatches.
// - Core checks and corrects external PHY too.
package spfmm_pkg;

  // ****************************************************************
  // Sizes and bus constants
  // ****************************************************************
  localparam int unsigned NPORT      = 3;
  localparam int unsigned TS_W       = 32;
  localparam int unsigned ERR_W      = 8;
  localparam logic [7:0]  ERR_MAX    = 8'hFF;
  localparam logic [2:0]  STRAP_SETTLE = 3'h4;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY = 1'b0;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFS_LOOP_CTRL = 8'h00;
  localparam logic [7:0] OFS_PORT_STAT = 8'h04;
  localparam logic [7:0] OFS_PHY_CTRL  = 8'h08;
  localparam logic [7:0] OFS_TS_P0     = 8'h0C;
  localparam logic [7:0] OFS_TS_P1     = 8'h10;
  localparam logic [7:0] OFS_TS_P2     = 8'h14;
  localparam logic [7:0] OFS_FRM_ERR   = 8'h18;

  localparam int unsigned ST_LINK_LSB    = 0;
  localparam int unsigned ST_CLOSED_LSB  = 3;
  localparam int unsigned ST_PRESENT_LSB = 6;
  localparam int unsigned ST_MODE_LSB    = 9;
  localparam int unsigned ST_STRAP_ERR   = 11;
  localparam int unsigned ST_CFG_BUSY    = 12;
  localparam int unsigned PC_FIBER_LSB   = 0;
  localparam int unsigned PC_RECHECK     = 8;
  localparam logic [2:0]  LOOP_CTRL_RST  = 3'h0;
  localparam logic [1:0]  FIBER_RST      = 2'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_2P  = 2'h0,
    MODE_RSV = 2'h1,
    MODE_3DN = 2'h2,
    MODE_3UP = 2'h3
  } spfmm_mode_t;

  localparam logic [1:0] PHY_A    = 2'h0;
  localparam logic [1:0] PHY_B    = 2'h1;
  localparam logic [1:0] PHY_MII  = 2'h2;
  localparam logic [1:0] PHY_NONE = 2'h3;

  typedef struct packed {
    logic       vld;
    logic       sof;
    logic       eof;
    logic       err;
    logic [7:0] data;
  } spfmm_beat_t;

  typedef struct packed {
    logic speed100;
    logic full_dup;
    logic an_en;
  } spfmm_phycfg_t;

  localparam spfmm_beat_t BEAT_IDLE = '0;

  // ****************************************************************
  // Port mapping
  // ****************************************************************
  function automatic logic [1:0] phy_of(input spfmm_mode_t m, input logic [1:0] lp);
    logic [1:0] r;
    r = PHY_NONE;
    case (m)
      MODE_3UP: r = (lp == 2'h0) ? PHY_MII : (lp == 2'h1) ? PHY_B : (lp == 2'h2) ? PHY_A : PHY_NONE;
      MODE_3DN: r = (lp == 2'h0) ? PHY_A : (lp == 2'h1) ? PHY_B : (lp == 2'h2) ? PHY_MII : PHY_NONE;
      default:  r = (lp == 2'h0) ? PHY_A : (lp == 2'h1) ? PHY_B : PHY_NONE;
    endcase
    return r;
  endfunction

  function automatic logic [1:0] lport_of(input spfmm_mode_t m, input logic [1:0] p);
    logic [1:0] r;
    r = PHY_NONE;
    for (int i = 0; i < NPORT; i++)
    begin
      if (phy_of(m, 2'(i)) == p)
      begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  function automatic spfmm_phycfg_t want_cfg(input logic [1:0] p, input logic [1:0] fiber);
    spfmm_phycfg_t c;
    c.speed100 = 1'b1;
    c.full_dup = 1'b1;
    c.an_en    = (p == PHY_MII) ? 1'b1 : ~fiber[p[0]];
    return c;
  endfunction

endpackage

//--- design/spfmm_sync.sv
// Three-stage synchroniser for pin inputs.
// Assumes asynchronous inputs; output follows once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module spfmm_sync
  import spfmm_pkg::*;
#(
  parameter int unsigned W = 1
)
(
  // Clock and reset
  input  wire logic         CORE_CLK,
  input  wire logic         RESET,
  // Data
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  // A bit changes only when two stages agree, filtering a one-cycle glitch.
  always_comb
  begin
    next_q = (s2 & s3) | (Q & (s2 ^ s3));
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      Q  <= '0;
    end
    else
    begin
      s1 <= D;
      s2 <= s1;
      s3 <= s2;
      Q  <= next_q;
    end
  end

endmodule
`default_nettype wire

//--- design/spfmm_top.sv
// Frame forwarding ring, port mapping and PHY default configuration.
// Assumes PHY streams on CORE_CLK, an AHB-Lite master, and a management agent.
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module spfmm_top
  import spfmm_pkg::*;
(
  // Clock and reset
  input  wire logic          CORE_CLK,
  input  wire logic          RESET,
  // Straps and link pins
  input  wire logic          PORT_CONFIG_STRAP_HI,
  input  wire logic          PORT_CONFIG_STRAP_LO,
  input  wire logic [2:0]    PHY_LINK,
  // Physical streams: A, B, external MII
  input  wire spfmm_beat_t   PHY_A_RX,
  input  wire spfmm_beat_t   PHY_B_RX,
  input  wire spfmm_beat_t   MII_RX,
  output spfmm_beat_t        PHY_A_TX,
  output spfmm_beat_t        PHY_B_TX,
  output spfmm_beat_t        MII_TX,
  // PHY management
  output logic               MGMT_REQ,
  output logic               MGMT_WR,
  output logic [1:0]         MGMT_SEL,
  output spfmm_phycfg_t      MGMT_WDATA,
  input  wire spfmm_phycfg_t MGMT_RDATA,
  input  wire logic          MGMT_ACK,
  // AHB-Lite slave
  input  wire logic          HSEL,
  input  wire logic [31:0]   HADDR,
  input  wire logic [1:0]    HTRANS,
  input  wire logic          HWRITE,
  input  wire logic [2:0]    HSIZE,
  input  wire logic [31:0]   HWDATA,
  input  wire logic          HREADY,
  output logic               HREADYOUT,
  output logic               HRESP,
  output logic [31:0]        HRDATA
);

  // ****************************************************************
  // Pin synchronisation and strap capture
  // ****************************************************************
  logic [4:0]  pins_q;
  logic [2:0]  link_p;
  logic [1:0]  strap;
  logic [2:0]  strap_cnt;
  logic [2:0]  next_strap_cnt;
  logic        strap_done;
  logic        next_strap_done;
  logic        strap_err;
  logic        next_strap_err;
  spfmm_mode_t port_mode;
  spfmm_mode_t next_port_mode;

  spfmm_sync #(.W(5)) u_sync (
    .CORE_CLK (CORE_CLK),
    .RESET    (RESET),
    .D        ({PORT_CONFIG_STRAP_HI, PORT_CONFIG_STRAP_LO, PHY_LINK}),
    .Q        (pins_q)
  );
  assign link_p = pins_q[2:0];
  assign strap  = pins_q[4:3];

  // The strap is taken once the synchroniser has settled after release.
  always_comb
  begin
    next_strap_cnt  = strap_cnt;
    next_strap_done = strap_done;
    next_strap_err  = strap_err;
    next_port_mode  = port_mode;
    if (!strap_done)
    begin
      if (strap_cnt == STRAP_SETTLE)
      begin
        next_strap_done = 1'b1;
        next_strap_err  = (strap == MODE_RSV);
        next_port_mode  = (strap == MODE_RSV) ? MODE_2P : spfmm_mode_t'(strap);
      end
      else
      begin
        next_strap_cnt = strap_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      strap_cnt  <= 3'h0;
      strap_done <= 1'b0;
      strap_err  <= 1'b0;
      port_mode  <= MODE_2P;
    end
    else
    begin
      strap_cnt  <= next_strap_cnt;
      strap_done <= next_strap_done;
      strap_err  <= next_strap_err;
      port_mode  <= next_port_mode;
    end
  end

  // ****************************************************************
  // Logical ports: mapping, loop state, checking, time stamps
  // ****************************************************************
  spfmm_beat_t rx_p [NPORT];
  spfmm_beat_t rx_l [NPORT];
  spfmm_beat_t tx_l [NPORT];
  logic [1:0]  pidx [NPORT];
  logic [2:0]  link_l;
  logic [2:0]  present;
  logic [2:0]  closed;
  logic [2:0]  loop_ctrl;
  logic [TS_W-1:0]  ts_cnt;
  logic [TS_W-1:0]  ts [NPORT];
  logic [ERR_W-1:0] err_cnt [NPORT];

  assign rx_p[0] = PHY_A_RX;
  assign rx_p[1] = PHY_B_RX;
  assign rx_p[2] = MII_RX;

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      ts_cnt <= '0;
    end
    else
    begin
      ts_cnt <= ts_cnt + 32'h1;
    end
  end

  for (genvar g = 0; g < NPORT; g++)
  begin : g_lport
    logic             bad;
    logic             next_bad;
    logic [TS_W-1:0]  next_ts;
    logic [ERR_W-1:0] next_err;

    assign pidx[g]    = phy_of(port_mode, 2'(g));
    assign present[g] = (pidx[g] != PHY_NONE);
    assign rx_l[g]    = present[g] ? rx_p[pidx[g]] : BEAT_IDLE;
    assign link_l[g]  = present[g] ? link_p[pidx[g]] : 1'b0;
    assign closed[g]  = !present[g] || !link_l[g] || loop_ctrl[g];

    always_comb
    begin
      next_ts  = ts[g];
      next_bad = bad;
      next_err = err_cnt[g];
      if (rx_l[g].vld)
      begin
        if (rx_l[g].sof)
        begin
          next_ts = ts_cnt;
        end
        next_bad = (rx_l[g].sof ? 1'b0 : bad) | rx_l[g].err;
        if (rx_l[g].eof)
        begin
          next_bad = 1'b0;
          if (next_err != ERR_MAX && ((rx_l[g].sof ? 1'b0 : bad) | rx_l[g].err))
          begin
            next_err = err_cnt[g] + 8'h01;
          end
        end
      end
    end

    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
      if (RESET)
      begin
        ts[g]      <= '0;
        bad        <= 1'b0;
        err_cnt[g] <= '0;
      end
      else
      begin
        ts[g]      <= next_ts;
        bad        <= next_bad;
        err_cnt[g] <= next_err;
      end
    end
  end

  // ****************************************************************
  // Forwarding ring
  // ****************************************************************
  // A loop that changes mid-frame cuts that frame; the error flag travels on with it.
  spfmm_beat_t fpu_in;
  spfmm_beat_t fpu_q;
  spfmm_beat_t seg1;
  spfmm_beat_t seg2;
  spfmm_beat_t tx_p [NPORT];
  spfmm_beat_t next_tx_p [NPORT];
  logic [1:0]  lidx [NPORT];

  always_comb
  begin
    seg1    = closed[1] ? fpu_q : rx_l[1];
    tx_l[1] = closed[1] ? BEAT_IDLE : fpu_q;
    seg2    = closed[2] ? seg1 : rx_l[2];
    tx_l[2] = closed[2] ? BEAT_IDLE : seg1;
    fpu_in  = closed[0] ? seg2 : rx_l[0];
    tx_l[0] = closed[0] ? BEAT_IDLE : seg2;
  end

  for (genvar p = 0; p < NPORT; p++)
  begin : g_phy
    assign lidx[p]      = lport_of(port_mode, 2'(p));
    assign next_tx_p[p] = (lidx[p] == PHY_NONE) ? BEAT_IDLE : tx_l[lidx[p]];
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      fpu_q <= BEAT_IDLE;
      for (int i = 0; i < NPORT; i++)
      begin
        tx_p[i] <= BEAT_IDLE;
      end
    end
    else
    begin
      fpu_q <= fpu_in;
      for (int i = 0; i < NPORT; i++)
      begin
        tx_p[i] <= next_tx_p[i];
      end
    end
  end

  assign PHY_A_TX = tx_p[0];
  assign PHY_B_TX = tx_p[1];
  assign MII_TX   = tx_p[2];

  // ****************************************************************
  // PHY configuration check
  // ****************************************************************
  typedef enum logic [5:0] {
    CF_WAIT  = 6'h01,
    CF_READ  = 6'h02,
    CF_CHECK = 6'h04,
    CF_WRITE = 6'h08,
    CF_NEXT  = 6'h10,
    CF_IDLE  = 6'h20
  } spfmm_cfst_t;

  spfmm_cfst_t   cf_state;
  spfmm_cfst_t   next_cf_state;
  logic [1:0]    cf_sel;
  logic [1:0]    next_cf_sel;
  spfmm_phycfg_t cf_rd;
  spfmm_phycfg_t next_cf_rd;
  spfmm_phycfg_t cf_want;
  spfmm_phycfg_t next_cf_want;
  logic [1:0]    fiber;
  logic          recheck;
  logic          mii_used;

  assign mii_used = (port_mode != MODE_2P);

  always_comb
  begin
    next_cf_state = cf_state;
    next_cf_sel   = cf_sel;
    next_cf_rd    = cf_rd;
    next_cf_want  = cf_want;
    case (cf_state)
      CF_WAIT:
      begin
        if (strap_done)
        begin
          next_cf_state = CF_READ;
        end
      end
      CF_READ:
      begin
        if (MGMT_ACK)
        begin
          next_cf_rd    = MGMT_RDATA;
          next_cf_state = CF_CHECK;
        end
      end
      CF_CHECK:
      begin
        next_cf_want  = want_cfg(cf_sel, fiber);
        next_cf_state = (cf_rd != want_cfg(cf_sel, fiber)) ? CF_WRITE : CF_NEXT;
      end
      CF_WRITE:
      begin
        if (MGMT_ACK)
        begin
          next_cf_state = CF_NEXT;
        end
      end
      CF_NEXT:
      begin
        if (cf_sel == PHY_MII || (cf_sel == PHY_B && !mii_used))
        begin
          next_cf_state = CF_IDLE;
          next_cf_sel   = PHY_A;
        end
        else
        begin
          next_cf_sel   = cf_sel + 2'h1;
          next_cf_state = CF_READ;
        end
      end
      CF_IDLE:
      begin
        if (recheck)
        begin
          next_cf_state = CF_READ;
        end
      end
      default:
      begin
        next_cf_state = CF_WAIT;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      cf_state <= CF_WAIT;
      cf_sel   <= PHY_A;
      cf_rd    <= '0;
      cf_want  <= '0;
    end
    else
    begin
      cf_state <= next_cf_state;
      cf_sel   <= next_cf_sel;
      cf_rd    <= next_cf_rd;
      cf_want  <= next_cf_want;
    end
  end

  assign MGMT_REQ   = (cf_state == CF_READ) || (cf_state == CF_WRITE);
  assign MGMT_WR    = (cf_state == CF_WRITE);
  assign MGMT_SEL   = cf_sel;
  assign MGMT_WDATA = cf_want;

  // ****************************************************************
  // AHB-Lite register slave
  // ****************************************************************
  // Zero wait states keep the slave simple; every access completes OKAY.
  logic        addr_ok;
  logic        take;
  logic        wr_pend;
  logic        next_wr_pend;
  logic [7:0]  wr_addr;
  logic [7:0]  next_wr_addr;
  logic [31:0] next_hrdata;
  logic [2:0]  next_loop_ctrl;
  logic [1:0]  next_fiber;
  logic        next_recheck;
  logic [31:0] stat;

  assign addr_ok = (HADDR[31:8] == 24'h000000) && (HADDR[1:0] == 2'h0);
  assign take    = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);

  always_comb
  begin
    stat = '0;
    stat[ST_LINK_LSB +: NPORT]    = link_l;
    stat[ST_CLOSED_LSB +: NPORT]  = closed;
    stat[ST_PRESENT_LSB +: NPORT] = present;
    stat[ST_MODE_LSB +: 2]        = port_mode;
    stat[ST_STRAP_ERR]            = strap_err;
    stat[ST_CFG_BUSY]             = (cf_state != CF_IDLE);
    next_wr_pend   = take && HWRITE && addr_ok;
    next_wr_addr   = HADDR[7:0];
    next_hrdata    = HRDATA;
    next_loop_ctrl = loop_ctrl;
    next_fiber     = fiber;
    next_recheck   = 1'b0;
    if (take && !HWRITE)
    begin
      next_hrdata = 32'h00000000;
      if (addr_ok)
      begin
        case (HADDR[7:0])
          OFS_LOOP_CTRL: next_hrdata[NPORT-1:0] = loop_ctrl;
          OFS_PORT_STAT: next_hrdata = stat;
          OFS_PHY_CTRL:  next_hrdata[PC_FIBER_LSB +: 2] = fiber;
          OFS_TS_P0:     next_hrdata = ts[0];
          OFS_TS_P1:     next_hrdata = ts[1];
          OFS_TS_P2:     next_hrdata = ts[2];
          OFS_FRM_ERR:   next_hrdata = {8'h00, err_cnt[2], err_cnt[1], err_cnt[0]};
          default:       next_hrdata = 32'h00000000;
        endcase
      end
    end
    if (wr_pend && wr_addr == OFS_LOOP_CTRL)
    begin
      next_loop_ctrl = HWDATA[NPORT-1:0];
    end
    if (wr_pend && wr_addr == OFS_PHY_CTRL)
    begin
      next_fiber   = HWDATA[PC_FIBER_LSB +: 2];
      next_recheck = HWDATA[PC_RECHECK];
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      HRDATA    <= 32'h00000000;
      loop_ctrl <= LOOP_CTRL_RST;
      fiber     <= FIBER_RST;
      recheck   <= 1'b0;
    end
    else
    begin
      wr_pend   <= next_wr_pend;
      wr_addr   <= next_wr_addr;
      HRDATA    <= next_hrdata;
      loop_ctrl <= next_loop_ctrl;
      fiber     <= next_fiber;
      recheck   <= next_recheck;
    end
  end

  assign HREADYOUT = 1'b1;
  assign HRESP     = HRESP_OKAY;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_ring_order: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    !closed[1] |=> PHY_B_TX == $past(fpu_q))
    else $error("Port 1 does not carry the processing unit output.");

  a_frame_check: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    rx_l[0].vld && rx_l[0].sof && rx_l[0].eof && rx_l[0].err && err_cnt[0] != ERR_MAX
    |=> err_cnt[0] == $past(err_cnt[0]) + 8'h01)
    else $error("Bad frame on port 0 was not counted.");

  a_stamp_sof: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    rx_l[1].vld && rx_l[1].sof |=> ts[1] == $past(ts_cnt))
    else $error("Port 1 time stamp not taken at start of frame.");

  a_loop_idle: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    closed[2] && port_mode == MODE_3DN |=> !MII_TX.vld)
    else $error("Closed port 2 still transmits.");

  a_port0_fpu: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    closed[0] |=> fpu_q == $past(seg2))
    else $error("Looped port 0 did not feed the processing unit.");

  a_master_close: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    wr_pend && wr_addr == OFS_LOOP_CTRL && HWDATA[0] |=> closed[0])
    else $error("Loop close write did not close port 0.");

  a_mode_fixed: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    strap_done |=> $stable(port_mode) && strap_done)
    else $error("Port configuration changed after capture.");

  a_map_up: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    port_mode == MODE_3UP && $stable(port_mode) |-> PHY_A_TX == $past(tx_l[2]))
    else $error("Upstream mode does not route port 2 to PHY A.");

  a_absent_closed: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    port_mode == MODE_2P |-> closed[2] && !MII_TX.vld)
    else $error("Absent port 2 is not looped back.");

  a_cfg_fix: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    cf_state == CF_CHECK && cf_rd != want_cfg(cf_sel, fiber)
    |=> MGMT_REQ && MGMT_WR && MGMT_WDATA == $past(want_cfg(cf_sel, fiber)))
    else $error("Mismatched PHY setting was not rewritten.");

endmodule
`default_nettype wire
